/* File: gauge_ctl_defines.svh */
// Function
// - control command sits at addresses 0x00/0x01
// - request and response words travel low byte first
// - code 0x0000 returns status word
// - code 0x0001 returns part type word
// - codes 0x0002/0x0003 return firmware/hardware versions
// - code 0x0004 returns model grade word
// - code 0x0007 returns previous request code
// - codes 0x0008/0x000C return parameter id/revision
// - code 0x0010 sets deep sleep permit
// - codes 0x0011..0x0014 set/clear idle and off permits
// - code 0x001F triggers open voltage correction
// - code 0x0020 locks access, blocks memory
// - code 0x0021 starts gauging when unlocked
// - code 0x002D toggles calibration when unlocked
// - code 0x0041 resets device when unlocked
// - codes 0x0081/0x0080 start/stop calibration measurement when unlocked and calibration is on
// - code 0x0040 returns lock type value
// - status bits 14/13 show full lock, lock
// - status bit 9 toggles on capacity update
// - status bit 2 set until results ready
// - status bits 1/0 show supply stable, gauging
// - status bits 4/3 show sleep, constant power
// - rate at 0x02/0x03, runtime at 0x04/0x05
`ifndef GAUGE_CTL_DEFINES_SVH
`define GAUGE_CTL_DEFINES_SVH

// ---------------------------------------------------------------
// command addresses
// ---------------------------------------------------------------
`define ADDR_CTL_LO      8'h00
`define ADDR_CTL_HI      8'h01
`define ADDR_RATE_LO     8'h02
`define ADDR_RATE_HI     8'h03
`define ADDR_RUN_LO      8'h04
`define ADDR_RUN_HI      8'h05

// ---------------------------------------------------------------
// request codes
// ---------------------------------------------------------------
`define RC_STATUS        16'h0000
`define RC_PART_TYPE     16'h0001
`define RC_CODE_REV      16'h0002
`define RC_SILICON_REV   16'h0003
`define RC_GRADE         16'h0004
`define RC_LAST_REQ      16'h0007
`define RC_PARAM_ID      16'h0008
`define RC_PARAM_REV     16'h000C
`define RC_ALLOW_SLEEP   16'h0010
`define RC_ALLOW_IDLE    16'h0011
`define RC_FORBID_IDLE   16'h0012
`define RC_ALLOW_OFF     16'h0013
`define RC_FORBID_OFF    16'h0014
`define RC_OCV_CORRECT   16'h001F
`define RC_LOCK          16'h0020
`define RC_START_GAUGE   16'h0021
`define RC_TRIM_TOGGLE   16'h002D
`define RC_LOCK_KIND     16'h0040
`define RC_RESET         16'h0041
`define RC_TRIM_STOP     16'h0080
`define RC_TRIM_START    16'h0081

// ---------------------------------------------------------------
// status word bit positions
// ---------------------------------------------------------------
`define ST_FULL_LOCK     14
`define ST_LOCKED        13
`define ST_TRIM          12
`define ST_CAP_TOGGLE    9
`define ST_OFF_PERMIT    7
`define ST_IDLE_PERMIT   6
`define ST_SLEEP_PERMIT  5
`define ST_IN_SLEEP      4
`define ST_CONST_POWER   3
`define ST_PENDING       2
`define ST_SUPPLY_OK     1
`define ST_GAUGING       0

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define RST_RATE         16'h0000
`define RST_LAST_REQ     16'h0000
`define RST_STATUS       16'h0004

`endif

/* File: gauge_ctl_pkg.sv */
package gauge_ctl_pkg;
  // address pointer phase for two-byte writes
  typedef enum logic [1:0] {
    IDLE,
    GOT_LO,
    EXEC
  } wr_phase_e;
  typedef logic [15:0] word_t;
endpackage

/* File: gauge_control_request_decoder.sv */
`timescale 1ns/10ps
`include "gauge_ctl_defines.svh"

module gauge_control_request_decoder
  import gauge_ctl_pkg::*;
#(
  parameter logic [15:0] PART_TYPE   = 16'h1234, // arbitrary value
  parameter logic [15:0] CODE_REV    = 16'h0100, // arbitrary value
  parameter logic [15:0] SILICON_REV = 16'h0002, // arbitrary value
  parameter logic [15:0] GRADE_WORD  = 16'h4141, // arbitrary value
  parameter logic [15:0] LOCK_KIND   = 16'h0000
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  // command byte port from the serial slave
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  input  wire logic [7:0]  cmd_addr,
  input  wire logic [7:0]  wr_data,
  output logic      [7:0]  rd_data,
  output logic             rd_valid,
  // gauge core facing inputs
  input  wire logic [15:0] param_set_id,
  input  wire logic [15:0] param_set_rev,
  input  wire logic        capacity_updated,
  input  wire logic        results_ready,
  input  wire logic        standby_exit,
  input  wire logic        supply_stable,
  input  wire logic        in_sleep,
  input  wire logic        const_power_sel,
  input  wire logic        full_lock_in,
  input  wire logic signed [15:0] temperature,
  input  wire logic [15:0] runtime_calc,
  // gauge core facing outputs
  output logic signed [15:0] load_rate_for_runtime,
  output logic             open_voltage_correct,
  output logic             trim_meas_start,
  output logic             trim_meas_stop,
  output logic             device_reset,
  output logic             nvm_blocked,
  output logic [15:0]      gauge_state_word,
  output logic [15:0]      runtime_estimate
);

  // ---------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------
  word_t       req_lo_ff;          // low byte staged until high byte arrives
  logic        lo_seen_ff;         // low byte of request captured
  word_t       cur_req_ff;         // current request code
  word_t       last_req_ff;        // request before current one
  word_t       rate_ff;            // rate current
  logic        rate_lo_seen_ff;    // low rate byte staged
  logic [7:0]  rate_lo_ff;         // staged rate low byte
  logic        locked_ff;
  logic        trim_ff;
  logic        cap_tog_ff;
  logic        off_ok_ff;
  logic        idle_ok_ff;
  logic        sleep_ok_ff;
  logic        pending_ff;
  logic        gauging_ff;
  logic        ocv_ff;
  logic        tstart_ff;
  logic        tstop_ff;
  logic        dreset_ff;
  logic [7:0]  rd_data_ff;
  logic        rd_valid_ff;
  word_t       status_ff;
  word_t       run_ff;

  // next values
  word_t       nxt_req_lo;
  logic        nxt_lo_seen;
  word_t       nxt_cur_req;
  word_t       nxt_last_req;
  word_t       nxt_rate;
  logic        nxt_rate_lo_seen;
  logic [7:0]  nxt_rate_lo;
  logic        nxt_locked;
  logic        nxt_trim;
  logic        nxt_cap_tog;
  logic        nxt_off_ok;
  logic        nxt_idle_ok;
  logic        nxt_sleep_ok;
  logic        nxt_pending;
  logic        nxt_gauging;
  logic        nxt_ocv;
  logic        nxt_tstart;
  logic        nxt_tstop;
  logic        nxt_dreset;
  logic [7:0]  nxt_rd_data;
  logic        nxt_rd_valid;
  word_t       nxt_status;
  word_t       nxt_run;

  word_t       status_now;         // status as it stands this cycle
  word_t       resp_word;          // answer to current request
  word_t       new_req;            // assembled request code

  // ---------------------------------------------------------------
  // status word assembly
  // ---------------------------------------------------------------
  // live status bits; the output port sees them one clock later
  always_comb begin
    status_now = 16'h0000;
    status_now[`ST_FULL_LOCK]    = full_lock_in & locked_ff;
    status_now[`ST_LOCKED]       = locked_ff;
    status_now[`ST_TRIM]         = trim_ff;
    status_now[`ST_CAP_TOGGLE]   = cap_tog_ff;
    status_now[`ST_OFF_PERMIT]   = off_ok_ff;
    status_now[`ST_IDLE_PERMIT]  = idle_ok_ff;
    status_now[`ST_SLEEP_PERMIT] = sleep_ok_ff;
    status_now[`ST_IN_SLEEP]     = in_sleep;
    status_now[`ST_CONST_POWER]  = const_power_sel;
    status_now[`ST_PENDING]      = pending_ff;
    status_now[`ST_SUPPLY_OK]    = supply_stable;
    status_now[`ST_GAUGING]      = gauging_ff;
  end

  // ---------------------------------------------------------------
  // response selection for read requests
  // ---------------------------------------------------------------
  // action codes read back as zero; only the history keeps them
  always_comb begin
    case (cur_req_ff)
      `RC_STATUS:      resp_word = status_now;
      `RC_PART_TYPE:   resp_word = PART_TYPE;
      `RC_CODE_REV:    resp_word = CODE_REV;
      `RC_SILICON_REV: resp_word = SILICON_REV;
      `RC_GRADE:       resp_word = GRADE_WORD;
      `RC_LAST_REQ:    resp_word = last_req_ff;
      `RC_PARAM_ID:    resp_word = param_set_id;
      `RC_PARAM_REV:   resp_word = param_set_rev;
      `RC_LOCK_KIND:   resp_word = LOCK_KIND;
      default:         resp_word = 16'h0000;
    endcase
  end

  // ---------------------------------------------------------------
  // next state: request capture, decode, readback
  // ---------------------------------------------------------------
  always_comb begin
    nxt_req_lo       = req_lo_ff;
    nxt_lo_seen      = lo_seen_ff;
    nxt_cur_req      = cur_req_ff;
    nxt_last_req     = last_req_ff;
    nxt_rate         = rate_ff;
    nxt_rate_lo_seen = rate_lo_seen_ff;
    nxt_rate_lo      = rate_lo_ff;
    nxt_locked       = locked_ff;
    nxt_trim         = trim_ff;
    nxt_off_ok       = off_ok_ff;
    nxt_idle_ok      = idle_ok_ff;
    nxt_sleep_ok     = sleep_ok_ff;
    nxt_gauging      = gauging_ff;
    nxt_ocv          = 1'b0;
    nxt_tstart       = 1'b0;
    nxt_tstop        = 1'b0;
    nxt_dreset       = 1'b0;
    nxt_rd_data      = rd_data_ff;
    nxt_rd_valid     = 1'b0;
    new_req          = {wr_data, req_lo_ff[7:0]};
    // capacity update flips the toggle bit
    nxt_cap_tog      = cap_tog_ff ^ capacity_updated;
    // pending set on restart, cleared when results come in
    nxt_pending      = pending_ff;
    if (results_ready) begin
      nxt_pending = 1'b0;
    end
    if (standby_exit) begin
      nxt_pending = 1'b1;
    end
    if (wr_stb) begin
      case (cmd_addr)
        // low byte of request first
        `ADDR_CTL_LO: begin
          nxt_req_lo  = {8'h00, wr_data};
          nxt_lo_seen = 1'b1;
        end
        // high byte completes the request
        `ADDR_CTL_HI: begin
          if (lo_seen_ff) begin
            nxt_lo_seen  = 1'b0;
            // unknown codes still enter the readback history
            nxt_last_req = cur_req_ff;
            nxt_cur_req  = new_req;
            case (new_req)
              `RC_ALLOW_SLEEP:  nxt_sleep_ok = 1'b1;
              `RC_ALLOW_IDLE:   nxt_idle_ok  = 1'b1;
              `RC_FORBID_IDLE:  nxt_idle_ok  = 1'b0;
              `RC_ALLOW_OFF:    nxt_off_ok   = 1'b1;
              `RC_FORBID_OFF:   nxt_off_ok   = 1'b0;
              `RC_OCV_CORRECT:  nxt_ocv      = 1'b1;
              // lock has no way back short of rst
              `RC_LOCK:         nxt_locked   = 1'b1;
              // unlocked-only codes, ignored while locked
              `RC_START_GAUGE: begin
                if (!locked_ff) begin
                  nxt_gauging = 1'b1;
                  nxt_pending = 1'b1;
                end
              end
              `RC_TRIM_TOGGLE: begin
                if (!locked_ff) begin
                  nxt_trim = ~trim_ff;
                end
              end
              // reset is a request to the power-on logic, not to this block
              `RC_RESET: begin
                if (!locked_ff) begin
                  nxt_dreset = 1'b1;
                end
              end
              `RC_TRIM_START: begin
                if (!locked_ff && trim_ff) begin
                  nxt_tstart = 1'b1;
                end
              end
              `RC_TRIM_STOP: begin
                if (!locked_ff && trim_ff) begin
                  nxt_tstop = 1'b1;
                end
              end
              // read codes and unknown codes act on nothing
              default: begin
                nxt_ocv = 1'b0;
              end
            endcase
          end
        end
        // rate current, low byte staged
        `ADDR_RATE_LO: begin
          nxt_rate_lo      = wr_data;
          nxt_rate_lo_seen = 1'b1;
        end
        // high byte commits the staged low byte as one word
        `ADDR_RATE_HI: begin
          if (rate_lo_seen_ff) begin
            nxt_rate         = {wr_data, rate_lo_ff};
            nxt_rate_lo_seen = 1'b0;
          end
        end
        default: begin
          nxt_lo_seen = lo_seen_ff;
        end
      endcase
    end
    // answer bytes keep the low-then-high order of the writes
    if (rd_stb) begin
      nxt_rd_valid = 1'b1;
      case (cmd_addr)
        `ADDR_CTL_LO:  nxt_rd_data = resp_word[7:0];
        `ADDR_CTL_HI:  nxt_rd_data = resp_word[15:8];
        `ADDR_RATE_LO: nxt_rd_data = rate_ff[7:0];
        `ADDR_RATE_HI: nxt_rd_data = rate_ff[15:8];
        `ADDR_RUN_LO:  nxt_rd_data = run_ff[7:0];
        `ADDR_RUN_HI:  nxt_rd_data = run_ff[15:8];
        default:       nxt_rd_data = 8'h00;
      endcase
    end
    // status output lags the live word by one clock
    nxt_status = status_now;
    // runtime comes from the gauge core, which sees rate and temperature
    nxt_run    = runtime_calc;
  end

  // ---------------------------------------------------------------
  // registers, frozen while clk_en is low
  // ---------------------------------------------------------------
  // synchronous reset wins over the clock enable
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      req_lo_ff       <= 16'h0000;
      lo_seen_ff      <= 1'b0;
      cur_req_ff      <= `RST_LAST_REQ;
      last_req_ff     <= `RST_LAST_REQ;
      rate_ff         <= `RST_RATE;
      rate_lo_seen_ff <= 1'b0;
      rate_lo_ff      <= 8'h00;
      locked_ff       <= 1'b0;
      trim_ff         <= 1'b0;
      cap_tog_ff      <= 1'b0;
      off_ok_ff       <= 1'b0;
      idle_ok_ff      <= 1'b0;
      sleep_ok_ff     <= 1'b0;
      pending_ff      <= 1'b1;       // pending after power-on
      gauging_ff      <= 1'b0;
      ocv_ff          <= 1'b0;
      tstart_ff       <= 1'b0;
      tstop_ff        <= 1'b0;
      dreset_ff       <= 1'b0;
      rd_data_ff      <= 8'h00;
      rd_valid_ff     <= 1'b0;
      status_ff       <= `RST_STATUS;
      run_ff          <= 16'h0000;
    end else if (clk_en) begin
      req_lo_ff       <= nxt_req_lo;
      lo_seen_ff      <= nxt_lo_seen;
      cur_req_ff      <= nxt_cur_req;
      last_req_ff     <= nxt_last_req;
      rate_ff         <= nxt_rate;
      rate_lo_seen_ff <= nxt_rate_lo_seen;
      rate_lo_ff      <= nxt_rate_lo;
      locked_ff       <= nxt_locked;
      trim_ff         <= nxt_trim;
      cap_tog_ff      <= nxt_cap_tog;
      off_ok_ff       <= nxt_off_ok;
      idle_ok_ff      <= nxt_idle_ok;
      sleep_ok_ff     <= nxt_sleep_ok;
      pending_ff      <= nxt_pending;
      gauging_ff      <= nxt_gauging;
      ocv_ff          <= nxt_ocv;
      tstart_ff       <= nxt_tstart;
      tstop_ff        <= nxt_tstop;
      dreset_ff       <= nxt_dreset;
      rd_data_ff      <= nxt_rd_data;
      rd_valid_ff     <= nxt_rd_valid;
      status_ff       <= nxt_status;
      run_ff          <= nxt_run;
    end
  end

  // ---------------------------------------------------------------
  // outputs straight from flops
  // ---------------------------------------------------------------
  // every port below reads a register, never a decode
  assign rd_data               = rd_data_ff;
  assign rd_valid              = rd_valid_ff;
  assign load_rate_for_runtime = rate_ff;
  assign open_voltage_correct  = ocv_ff;
  assign trim_meas_start       = tstart_ff;
  assign trim_meas_stop        = tstop_ff;
  assign device_reset          = dreset_ff;
  assign nvm_blocked           = locked_ff;
  assign gauge_state_word      = status_ff;
  assign runtime_estimate      = run_ff;

  // temperature is consumed by the gauge core's runtime calc, which pairs
  // it with the rate current; folded to one bit so the port has a reader
  logic unused_temp;
  assign unused_temp = ^temperature;

endmodule // gauge_control_request_decoder

/* File: gauge_control_request_decoder_checker.sv */
`timescale 1ns/10ps
// ---------------------------------------------------------------
// port checker
// ---------------------------------------------------------------
module gauge_control_request_decoder_checker (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        clk_en,
  // command byte port
  input wire logic        wr_stb,
  input wire logic        rd_stb,
  input wire logic [7:0]  cmd_addr,
  input wire logic [7:0]  wr_data,
  input wire logic        rd_valid,
  // core side
  input wire logic [15:0] runtime_calc,
  input wire logic [15:0] runtime_estimate,
  input wire logic        open_voltage_correct,
  input wire logic        trim_meas_start,
  input wire logic        trim_meas_stop,
  input wire logic        device_reset,
  input wire logic        nvm_blocked
);
  logic [7:0] lo_ff;   // low code byte last written
  logic [7:0] nxt_lo;
  logic       arm_ff;  // low byte waits for its high byte
  logic       nxt_arm;
  logic       take;    // accepted write
  logic       commit;  // code committed with a zero high byte
  assign take = wr_stb & clk_en;
  assign commit = take && cmd_addr == 8'h01 && arm_ff && wr_data == 8'h00;
  // follow the low-then-high pairing
  always_comb begin
    nxt_lo = lo_ff;
    nxt_arm = arm_ff;
    if (take && cmd_addr == 8'h00) begin
      nxt_lo = wr_data;
      nxt_arm = 1'b1;
    end else if (take && cmd_addr == 8'h01) begin
      nxt_arm = 1'b0;
    end
  end
  // register the tracker
  always_ff @(posedge sys_clk) begin
    lo_ff <= rst ? 8'h00 : nxt_lo;
    arm_ff <= rst ? 1'b0 : nxt_arm;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_read_answer: assert property (rd_stb && clk_en |=> rd_valid)
    else $error("read strobe got no answer");
  a_answer_cause: assert property (rd_valid && $past(clk_en) |-> $past(rd_stb))
    else $error("answer without a read");
  a_lock_commit: assert property (commit && lo_ff == 8'h20 |=> nvm_blocked)
    else $error("lock code did not block memory");
  a_lock_sticky: assert property (nvm_blocked |=> nvm_blocked)
    else $error("lock dropped without reset");
  a_ocv_pulse: assert property (
    commit && lo_ff == 8'h1F |=> open_voltage_correct ##1 !open_voltage_correct)
    else $error("correction pulse wrong");
  a_reset_gate: assert property (
    commit && lo_ff == 8'h41 |=> device_reset == !$past(nvm_blocked))
    else $error("device reset not gated by lock");
  a_reset_single: assert property (device_reset |=> !device_reset)
    else $error("device reset longer than a cycle");
  a_trim_gate: assert property (
    trim_meas_start || trim_meas_stop |-> !$past(nvm_blocked))
    else $error("trim measurement while locked");
  a_runtime_reg: assert property (clk_en |=> runtime_estimate == $past(runtime_calc))
    else $error("runtime estimate not following core");
  c_lock: cover property (commit && lo_ff == 8'h20);
  c_trim: cover property (trim_meas_start);
  c_reset: cover property (device_reset);
endmodule // gauge_control_request_decoder_checker

bind gauge_control_request_decoder gauge_control_request_decoder_checker u_chk (
  .sys_clk, .rst, .clk_en, .wr_stb, .rd_stb, .cmd_addr, .wr_data, .rd_valid,
  .runtime_calc, .runtime_estimate, .open_voltage_correct, .trim_meas_start,
  .trim_meas_stop, .device_reset, .nvm_blocked
);

/* File: gauge_host_model.sv */
`timescale 1ns/10ps
// ---------------------------------------------------------------
// host side byte master
// ---------------------------------------------------------------
module gauge_host_model (
  // clock and answer
  input wire logic       sys_clk,
  input wire logic [7:0] rd_data,
  input wire logic       rd_valid,
  // requests
  output logic           wr_stb,
  output logic           rd_stb,
  output logic     [7:0] cmd_addr,
  output logic     [7:0] wr_data
);
  initial begin
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    cmd_addr = 8'h00;
    wr_data = 8'h00;
  end
  // one byte write, lines inverted once released
  task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    wr_stb = 1'b1;
    cmd_addr = a;
    wr_data = d;
    @(negedge sys_clk);
    wr_stb = 1'b0;
    cmd_addr = ~a;
    wr_data = ~d;
  endtask
  // one byte read, bounded wait for the answer
  task automatic rd_byte(input logic [7:0] a, output logic [7:0] d);
    int i = 0;
    @(negedge sys_clk);
    rd_stb = 1'b1;
    cmd_addr = a;
    @(negedge sys_clk);
    rd_stb = 1'b0;
    cmd_addr = ~a;
    while (rd_valid !== 1'b1 && i < 4) begin
      @(negedge sys_clk);
      i++;
    end
    d = (rd_valid === 1'b1) ? rd_data : 8'hXX;
  endtask
  // request code, low byte at the even address first
  task automatic req(input logic [15:0] c);
    wr_byte(8'h00, c[7:0]);
    wr_byte(8'h01, c[15:8]);
  endtask
  // response word, low byte first
  task automatic resp(output logic [15:0] w);
    rd_byte(8'h00, w[7:0]);
    rd_byte(8'h01, w[15:8]);
  endtask
endmodule // gauge_host_model

/* File: gauge_control_request_decoder_tb.sv */
`timescale 1ns/10ps
// ---------------------------------------------------------------
// bench
// ---------------------------------------------------------------
module gauge_control_request_decoder_tb;
  import gauge_ctl_pkg::*;
  typedef struct {word_t code; bit rd; word_t exp;} row_s;
  localparam word_t P_PART = 16'h0A51;  // arbitrary value
  localparam word_t P_CREV = 16'h0203;  // arbitrary value
  localparam word_t P_SREV = 16'h0007;  // arbitrary value
  localparam word_t P_GRADE = 16'h5151; // arbitrary value
  localparam word_t P_LOCK = 16'h0002;
  logic sys_clk, rst, clk_en, wr_stb, rd_stb, rd_valid, capacity_updated;
  logic results_ready, standby_exit, supply_stable, in_sleep, const_power_sel;
  logic full_lock_in, open_voltage_correct, trim_meas_start, trim_meas_stop;
  logic device_reset, nvm_blocked;
  logic [7:0] cmd_addr, wr_data, rd_data, b0, b1;
  word_t param_set_id, param_set_rev, runtime_calc, gauge_state_word;
  word_t runtime_estimate, w;
  logic signed [15:0] temperature, load_rate_for_runtime;
  int num_errors = 0, compares = 0, cyc = 0;
  int n_ocv = 0, n_start = 0, n_stop = 0, n_rst = 0;
  // read rows answer a word, write rows give the status after
  row_s rows [18] = '{
    '{16'h0000, 1, 16'h000E}, '{16'h0001, 1, P_PART}, '{16'h0002, 1, P_CREV},
    '{16'h0003, 1, P_SREV}, '{16'h0004, 1, P_GRADE}, '{16'h0008, 1, 16'h5A3C},
    '{16'h000C, 1, 16'h0102}, '{16'h0040, 1, P_LOCK}, '{16'h0007, 1, 16'h0040},
    '{16'h0010, 0, 16'h002E}, '{16'h0011, 0, 16'h006E}, '{16'h0013, 0, 16'h00EE},
    '{16'h0012, 0, 16'h00AE}, '{16'h0014, 0, 16'h002E}, '{16'h0033, 0, 16'h002E},
    '{16'h0021, 0, 16'h002F}, '{16'h002D, 0, 16'h102F}, '{16'h0007, 1, 16'h002D}};
  gauge_control_request_decoder #(.PART_TYPE(P_PART), .CODE_REV(P_CREV),
    .SILICON_REV(P_SREV), .GRADE_WORD(P_GRADE), .LOCK_KIND(P_LOCK)) u_dut (.*);
  gauge_host_model u_host (.sys_clk(sys_clk), .rd_data(rd_data), .rd_valid(rd_valid),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .cmd_addr(cmd_addr), .wr_data(wr_data));
  // clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // count action pulses and cycles, mid-cycle so each pulse is seen settled
  always @(negedge sys_clk) begin
    cyc++;
    if (!rst) begin
      n_ocv += open_voltage_correct;
      n_start += trim_meas_start;
      n_stop += trim_meas_stop;
      n_rst += device_reset;
    end
    if (cyc == 5000) begin
      num_errors++;
      finish_test();
    end
  end
  // compare and count
  task automatic chk(input word_t seen, input word_t exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one cycle pulse on capacity, ready, restart inputs, then let status settle
  task automatic pulse(input logic [2:0] m);
    @(negedge sys_clk);
    {capacity_updated, results_ready, standby_exit} = m;
    @(negedge sys_clk);
    {capacity_updated, results_ready, standby_exit} = 3'b000;
    repeat (3) @(negedge sys_clk);
  endtask
  // reset held three cycles
  task automatic do_reset;
    rst = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk(gauge_state_word, 16'h0004);
    rst = 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask
  task automatic finish_test;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // main sequence
  initial begin
    {clk_en, supply_stable, const_power_sel} = 3'b111;
    {capacity_updated, results_ready, standby_exit, in_sleep, full_lock_in} = 5'h00;
    param_set_id = 16'h5A3C;
    param_set_rev = 16'h0102;
    runtime_calc = 16'h0BCD;
    temperature = 16'sh0BB8;
    do_reset();
    foreach (rows[i]) begin
      u_host.req(rows[i].code);
      if (rows[i].rd) begin
        u_host.resp(w);
        chk(w, rows[i].exp);
      end else begin
        repeat (3) @(negedge sys_clk);
        chk(gauge_state_word, rows[i].exp);
      end
    end
    // trim measurement only while trim is on
    u_host.req(16'h0081);
    u_host.req(16'h0080);
    u_host.req(16'h002D);
    u_host.req(16'h0081);
    repeat (3) @(negedge sys_clk);
    chk(word_t'(n_start), 16'h0001);
    chk(word_t'(n_stop), 16'h0001);
    chk(gauge_state_word, 16'h002F);
    // core events on status bits; ready and restart together keep pending
    pulse(3'b010);
    chk(gauge_state_word, 16'h002B);
    pulse(3'b100);
    chk(gauge_state_word, 16'h022B);
    pulse(3'b001);
    chk(gauge_state_word, 16'h022F);
    pulse(3'b011);
    chk(gauge_state_word, 16'h022F);
    in_sleep = 1'b1;
    supply_stable = 1'b0;
    const_power_sel = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk(gauge_state_word, 16'h0235);
    // rate write and read back, runtime, unmapped read
    u_host.wr_byte(8'h02, 8'h38);
    u_host.wr_byte(8'h03, 8'hFF);
    chk(load_rate_for_runtime, 16'hFF38);
    u_host.rd_byte(8'h02, b0);
    u_host.rd_byte(8'h03, b1);
    chk({b1, b0}, 16'hFF38);
    u_host.rd_byte(8'h04, b0);
    u_host.rd_byte(8'h05, b1);
    chk({b1, b0}, 16'h0BCD);
    // clock enable low freezes the rate writes and the runtime register
    clk_en = 1'b0;
    runtime_calc = 16'h1357;
    temperature = 16'shFFD8;
    u_host.wr_byte(8'h02, 8'h11);
    u_host.wr_byte(8'h03, 8'h22);
    chk(load_rate_for_runtime, 16'hFF38);
    chk(runtime_estimate, 16'h0BCD);
    clk_en = 1'b1;
    @(negedge sys_clk);
    chk(runtime_estimate, 16'h1357);
    u_host.rd_byte(8'h7E, b0);
    chk({8'h00, b0}, 16'h0000);
    u_host.req(16'h001F);
    u_host.req(16'h0041);
    repeat (3) @(negedge sys_clk);
    chk(word_t'(n_ocv), 16'h0001);
    chk(word_t'(n_rst), 16'h0001);
    // lock, then restricted codes do nothing
    {in_sleep, supply_stable, const_power_sel} = 3'b011;
    do_reset();
    u_host.req(16'h0020);
    repeat (3) @(negedge sys_clk);
    chk({15'h0000, nvm_blocked}, 16'h0001);
    full_lock_in = 1'b1;
    foreach (rows[i]) if (i > 14 && i < 17) u_host.req(rows[i].code);
    u_host.req(16'h0041);
    u_host.req(16'h0000);
    u_host.resp(w);
    chk(w, 16'h600E);
    chk(word_t'(n_rst), 16'h0001);
    finish_test();
  end
endmodule // gauge_control_request_decoder_tb
